/* include/albe_pkg.sv */
package albe_pkg;

  localparam int unsigned PC_W  = 16;
  localparam int unsigned REG_N = 32;

  // Instruction set handled by the execution unit.
  typedef enum logic [5:0] {
    OP_NOP, OP_SUM_REGS, OP_SUM_WITH_CARRY_IN, OP_WORD_ADD_IMMEDIATE,
    OP_DIFF_REGS, OP_DIFFERENCE_IMMEDIATE, OP_DIFFERENCE_WITH_BORROW,
    OP_DIFFERENCE_IMMEDIATE_BORROW, OP_WORD_SUBTRACT_IMMEDIATE,
    OP_CONJ_REGS, OP_CONJ_IMMEDIATE, OP_DISJ_REGS, OP_DISJ_IMMEDIATE,
    OP_BITWISE_XOR_REGS, OP_BITS_SET_MASK, OP_BITS_CLEAR_MASK,
    OP_PLUS_ONE, OP_MINUS_ONE, OP_ZERO_SIGN_PROBE, OP_ZERO_FILL,
    OP_ONES_FILL, OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED,
    OP_FRACTION_PRODUCT_UNSIGNED, OP_FRACTION_PRODUCT_SIGNED,
    OP_FRACTION_PRODUCT_MIXED, OP_RELATIVE_GOTO, OP_POINTER_GOTO,
    OP_ABSOLUTE_GOTO, OP_RELATIVE_SUBROUTINE_INVOKE,
    OP_POINTER_SUBROUTINE_INVOKE, OP_ABSOLUTE_SUBROUTINE_INVOKE,
    OP_EQUAL_COMPARE_SKIP, OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY_IN,
    OP_COMPARE_IMMEDIATE, OP_SKIP_REG_BIT_LOW, OP_SKIP_REG_BIT_HIGH,
    OP_SKIP_PORT_BIT_LOW, OP_SKIP_PORT_BIT_HIGH, OP_BRANCH_FLAG_HIGH,
    OP_BRANCH_FLAG_LOW, OP_BRANCH_ON_EQUAL, OP_BRANCH_UNEQUAL,
    OP_BRANCH_CARRY_HIGH, OP_BRANCH_CARRY_LOW, OP_BRANCH_UNSIGNED_GE
  } albe_op_t;

  // Execution state: ready for an instruction or finishing a multi-cycle one.
  typedef enum logic [1:0] {
    ST_READY = 2'b01,
    ST_BUSY  = 2'b10
  } albe_state_t;

  // Issued instruction, already decoded; k is sign-extended by the decoder.
  typedef struct packed {
    albe_op_t          op;
    logic [4:0]        rd;
    logic [4:0]        rr;
    logic [7:0]        imm;
    logic [PC_W-1:0]   k;
    logic [2:0]        bit_sel;
    logic              next_long;
    logic              port_bit;
  } albe_instr_t;

  // Register file load port used by the surrounding data-transfer logic.
  typedef struct packed {
    logic       en;
    logic [4:0] idx;
    logic [7:0] data;
  } albe_load_t;

  // Flag register bit positions.
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;

  localparam logic [4:0] IDX_PROD_LO = 5'h00;
  localparam logic [4:0] IDX_PROD_HI = 5'h01;
  localparam logic [4:0] IDX_PTR_LO  = 5'h1E;
  localparam logic [4:0] IDX_PTR_HI  = 5'h1F;
  localparam logic [4:0] IDX_PAIR    = 5'h01;

  localparam logic [7:0]      BYTE_ONES  = 8'hFF;
  localparam logic [7:0]      BYTE_ZERO  = 8'h00;
  localparam logic [7:0]      BYTE_ONE   = 8'h01;
  localparam logic [7:0]      BYTE_MSB   = 8'h80;
  localparam logic [7:0]      BYTE_MAXP  = 8'h7F;
  localparam logic [PC_W-1:0] PC_RESET   = 16'h0000;
  localparam logic [PC_W-1:0] PC_STEP    = 16'h0001;
  localparam logic [PC_W-1:0] PC_SKIP1   = 16'h0002;
  localparam logic [PC_W-1:0] PC_SKIP2   = 16'h0003;

  // Cycle counts per instruction class.
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;

endpackage

/* verilog/albe_mult.sv */
`timescale 1ns/1ps
module albe_mult
  import albe_pkg::*;
(
  // Operands and their signedness.
  input  wire logic [7:0]  mul_a,
  input  wire logic [7:0]  mul_b,
  input  wire logic        signed_a,
  input  wire logic        signed_b,
  input  wire logic        fraction,
  // Product and carry.
  output logic      [15:0] product,
  output logic             carry
);

  logic signed [8:0]  ext_a;
  logic signed [8:0]  ext_b;
  logic signed [17:0] full;
  logic        [15:0] raw;

  assign ext_a = $signed({signed_a & mul_a[7], mul_a});
  assign ext_b = $signed({signed_b & mul_b[7], mul_b});
  assign full  = ext_a * ext_b;
  assign raw   = full[15:0];
  // Carry is the top product bit before the fractional shift.
  assign carry   = raw[15];
  assign product = fraction ? {raw[14:0], 1'b0} : raw;

endmodule

/* verilog/albe_exec_core.sv */
// Behaviour
// [RULE1] Register add, optional carry in, one cycle
// [RULE2] Subtract register or immediate, optional borrow
// [RULE3] Word add/subtract immediate, two cycles
// [RULE4] AND, OR, XOR set Z, N, V only
// [RULE5] Set or clear bits by immediate mask
// [RULE6] Increment, decrement, probe, clear, fill ones
// [RULE7] Multiplies into R1:R0, two cycles
// [RULE8] Fractional multiplies shift product left one
// [RULE9] Relative, pointer and absolute jumps
// [RULE10] Relative, pointer and absolute subroutine calls
// [RULE11] Compare registers, skip next when equal
// [RULE12] Compares set flags, store nothing
// [RULE13] Skip on general register bit value
// [RULE14] Skip on I/O register bit value
// [RULE15] Branch on selected flag bit
// [RULE16] Branch on zero or carry flag
// [RULE17] Branch when carry clear, unsigned greater-equal
// [RULE18] Untaken one cycle; taken two; skip two/three
`timescale 1ns/1ps
module albe_exec_core
  import albe_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // Instruction issue.
  input  wire logic              issue_valid,
  input  wire albe_instr_t       issue,
  output logic                   issue_ready_q,
  output logic                   done_q,
  // Register file load and inspection.
  input  wire albe_load_t        load,
  input  wire logic [4:0]        peek_idx,
  output logic      [7:0]        peek_data_q,
  // Flag register load.
  input  wire logic              flags_load_en,
  input  wire logic [7:0]        flags_load_data,
  // Architectural state.
  output logic      [PC_W-1:0]   pc_q,
  output logic      [7:0]        flag_register_q,
  // Return address for the stack logic.
  output logic                   push_q,
  output logic      [PC_W-1:0]   ret_addr_q
);

  logic [7:0]        rf_q [REG_N];
  albe_state_t       state_q;
  logic [2:0]        cnt_q;
  logic              accept;
  logic [7:0]        rd_v;
  logic [7:0]        rr_v;
  logic [7:0]        hi_v;
  logic [7:0]        op_b;
  logic [8:0]        s9;
  logic [15:0]       w16;
  logic [15:0]       r16;
  logic [7:0]        res8;
  logic              wr8;
  logic              wr16;
  logic [4:0]        dst_lo;
  logic [4:0]        dst_hi;
  logic [7:0]        nf;
  logic [PC_W-1:0]   pc_d;
  logic [2:0]        cyc;
  logic              push_d;
  logic [PC_W-1:0]   ret_d;
  logic              cond;
  logic              mul_sa;
  logic              mul_sb;
  logic              mul_fr;
  logic [15:0]       prod;
  logic              prod_c;

  // Half-carry and overflow of an 8-bit add, returned as {h, v}.
  function automatic logic [1:0] add_hv(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic [7:0] r);
    add_hv[1] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
    add_hv[0] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
  endfunction

  // Half-borrow and overflow of an 8-bit subtract, returned as {h, v}.
  function automatic logic [1:0] sub_hv(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic [7:0] r);
    sub_hv[1] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    sub_hv[0] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
  endfunction

  assign accept = issue_valid && (state_q == ST_READY);
  assign rd_v   = rf_q[issue.rd];
  assign rr_v   = rf_q[issue.rr];
  assign dst_hi = issue.rd + IDX_PAIR;
  assign hi_v   = rf_q[dst_hi];
  assign w16    = {hi_v, rd_v};

  always_comb begin
    mul_sa = 1'b0;
    mul_sb = 1'b0;
    mul_fr = 1'b0;
    case (issue.op)
      OP_PRODUCT_SIGNED:            begin mul_sa = 1'b1; mul_sb = 1'b1; end
      OP_PRODUCT_MIXED:             mul_sa = 1'b1;
      OP_FRACTION_PRODUCT_UNSIGNED: mul_fr = 1'b1;
      OP_FRACTION_PRODUCT_SIGNED: begin
        mul_sa = 1'b1;
        mul_sb = 1'b1;
        mul_fr = 1'b1;
      end
      OP_FRACTION_PRODUCT_MIXED:    begin mul_sa = 1'b1; mul_fr = 1'b1; end
      default:                      mul_fr = 1'b0;
    endcase
  end

  albe_mult u_mult (
    .mul_a    (rd_v),
    .mul_b    (rr_v),
    .signed_a (mul_sa),
    .signed_b (mul_sb),
    .fraction (mul_fr),
    .product  (prod),
    .carry    (prod_c)
  );

  always_comb begin
    op_b   = rr_v;
    s9     = 9'h000;
    r16    = 16'h0000;
    res8   = BYTE_ZERO;
    wr8    = 1'b0;
    wr16   = 1'b0;
    dst_lo = issue.rd;
    nf     = flag_register_q;
    pc_d   = pc_q + PC_STEP;
    cyc    = CYC_1;
    push_d = 1'b0;
    ret_d  = pc_q + PC_STEP;
    cond   = 1'b0;
    case (issue.op)
      OP_SUM_REGS, OP_SUM_WITH_CARRY_IN: begin
        s9 = {1'b0, rd_v} + {1'b0, rr_v} + {8'h00, flag_register_q[FLAG_C]
             & (issue.op == OP_SUM_WITH_CARRY_IN)};                 // [RULE1]
        res8 = s9[7:0];
        wr8  = 1'b1;
        {nf[FLAG_H], nf[FLAG_V]} = add_hv(rd_v, rr_v, res8);        // [RULE1]
        nf[FLAG_C] = s9[8];
        nf[FLAG_N] = res8[7];
        nf[FLAG_Z] = (res8 == BYTE_ZERO);
      end
      OP_DIFF_REGS, OP_DIFFERENCE_IMMEDIATE, OP_DIFFERENCE_WITH_BORROW,
      OP_DIFFERENCE_IMMEDIATE_BORROW, OP_COMPARE_REGS,
      OP_COMPARE_WITH_CARRY_IN, OP_COMPARE_IMMEDIATE: begin
        if (issue.op == OP_DIFFERENCE_IMMEDIATE ||
            issue.op == OP_DIFFERENCE_IMMEDIATE_BORROW ||
            issue.op == OP_COMPARE_IMMEDIATE) begin
          op_b = issue.imm;
        end
        s9 = {1'b0, rd_v} - {1'b0, op_b} - {8'h00, flag_register_q[FLAG_C]
             & (issue.op == OP_DIFFERENCE_WITH_BORROW ||
                issue.op == OP_DIFFERENCE_IMMEDIATE_BORROW ||
                issue.op == OP_COMPARE_WITH_CARRY_IN)};             // [RULE2]
        res8 = s9[7:0];
        // Compares keep the difference out of the register file.
        wr8  = !(issue.op == OP_COMPARE_REGS ||
                 issue.op == OP_COMPARE_WITH_CARRY_IN ||
                 issue.op == OP_COMPARE_IMMEDIATE);                 // [RULE12]
        {nf[FLAG_H], nf[FLAG_V]} = sub_hv(rd_v, op_b, res8);   // [RULE2] [RULE12]
        nf[FLAG_C] = s9[8];
        nf[FLAG_N] = res8[7];
        nf[FLAG_Z] = (res8 == BYTE_ZERO);
      end
      OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE: begin
        if (issue.op == OP_WORD_ADD_IMMEDIATE) begin
          r16 = w16 + {8'h00, issue.imm};                           // [RULE3]
          nf[FLAG_V] = ~hi_v[7] & r16[15];
          nf[FLAG_C] = ~r16[15] & hi_v[7];
        end else begin
          r16 = w16 - {8'h00, issue.imm};                           // [RULE3]
          nf[FLAG_V] = hi_v[7] & ~r16[15];
          nf[FLAG_C] = r16[15] & ~hi_v[7];
        end
        wr16 = 1'b1;
        cyc  = CYC_2;                                               // [RULE3]
        nf[FLAG_N] = r16[15];
        nf[FLAG_Z] = (r16 == 16'h0000);
        nf[FLAG_S] = r16[15] ^ nf[FLAG_V];
      end
      OP_CONJ_REGS, OP_CONJ_IMMEDIATE, OP_DISJ_REGS, OP_DISJ_IMMEDIATE,
      OP_BITWISE_XOR_REGS, OP_BITS_SET_MASK, OP_BITS_CLEAR_MASK,
      OP_ZERO_SIGN_PROBE, OP_ZERO_FILL, OP_PLUS_ONE, OP_MINUS_ONE: begin
        case (issue.op)
          OP_CONJ_REGS:        res8 = rd_v & rr_v;                  // [RULE4]
          OP_CONJ_IMMEDIATE:   res8 = rd_v & issue.imm;             // [RULE4]
          OP_DISJ_REGS:        res8 = rd_v | rr_v;                  // [RULE4]
          OP_DISJ_IMMEDIATE:   res8 = rd_v | issue.imm;             // [RULE4]
          OP_BITWISE_XOR_REGS: res8 = rd_v ^ rr_v;                  // [RULE4]
          OP_BITS_SET_MASK:    res8 = rd_v | issue.imm;             // [RULE5]
          OP_BITS_CLEAR_MASK:  res8 = rd_v & (BYTE_ONES - issue.imm); // [RULE5]
          OP_ZERO_SIGN_PROBE:  res8 = rd_v & rd_v;                  // [RULE6]
          OP_ZERO_FILL:        res8 = rd_v ^ rd_v;                  // [RULE6]
          OP_PLUS_ONE:         res8 = rd_v + BYTE_ONE;              // [RULE6]
          default:             res8 = rd_v - BYTE_ONE;              // [RULE6]
        endcase
        wr8 = 1'b1;
        nf[FLAG_N] = res8[7];
        nf[FLAG_Z] = (res8 == BYTE_ZERO);
        if (issue.op == OP_PLUS_ONE) begin
          nf[FLAG_V] = (res8 == BYTE_MSB);                          // [RULE6]
        end else if (issue.op == OP_MINUS_ONE) begin
          nf[FLAG_V] = (res8 == BYTE_MAXP);                         // [RULE6]
        end else begin
          nf[FLAG_V] = 1'b0;                                   // [RULE4] [RULE5]
        end
      end
      OP_ONES_FILL: begin
        res8 = BYTE_ONES;                                           // [RULE6]
        wr8  = 1'b1;
      end
      OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED,
      OP_FRACTION_PRODUCT_UNSIGNED, OP_FRACTION_PRODUCT_SIGNED,
      OP_FRACTION_PRODUCT_MIXED: begin
        r16    = prod;                                         // [RULE7] [RULE8]
        dst_lo = IDX_PROD_LO;
        wr16   = 1'b1;
        cyc    = CYC_2;                                        // [RULE7] [RULE8]
        nf[FLAG_C] = prod_c;
        nf[FLAG_Z] = (prod == 16'h0000);
      end
      OP_RELATIVE_GOTO: begin
        pc_d = pc_q + issue.k + PC_STEP;                            // [RULE9]
        cyc  = CYC_2;
      end
      OP_POINTER_GOTO: begin
        pc_d = {rf_q[IDX_PTR_HI], rf_q[IDX_PTR_LO]};                // [RULE9]
        cyc  = CYC_2;
      end
      OP_ABSOLUTE_GOTO: begin
        pc_d = issue.k;                                             // [RULE9]
        cyc  = CYC_3;
      end
      OP_RELATIVE_SUBROUTINE_INVOKE: begin
        pc_d   = pc_q + issue.k + PC_STEP;                          // [RULE10]
        cyc    = CYC_3;
        push_d = 1'b1;
      end
      OP_POINTER_SUBROUTINE_INVOKE: begin
        pc_d   = {rf_q[IDX_PTR_HI], rf_q[IDX_PTR_LO]};              // [RULE10]
        cyc    = CYC_3;
        push_d = 1'b1;
      end
      OP_ABSOLUTE_SUBROUTINE_INVOKE: begin
        pc_d   = issue.k;                                           // [RULE10]
        cyc    = CYC_4;
        push_d = 1'b1;
        ret_d  = pc_q + PC_SKIP1;
      end
      OP_EQUAL_COMPARE_SKIP, OP_SKIP_REG_BIT_LOW, OP_SKIP_REG_BIT_HIGH,
      OP_SKIP_PORT_BIT_LOW, OP_SKIP_PORT_BIT_HIGH: begin
        case (issue.op)
          OP_EQUAL_COMPARE_SKIP: cond = (rd_v == rr_v);             // [RULE11]
          OP_SKIP_REG_BIT_LOW:   cond = !rr_v[issue.bit_sel];       // [RULE13]
          OP_SKIP_REG_BIT_HIGH:  cond = rr_v[issue.bit_sel];        // [RULE13]
          OP_SKIP_PORT_BIT_LOW:  cond = !issue.port_bit;            // [RULE14]
          default:               cond = issue.port_bit;             // [RULE14]
        endcase
        if (cond) begin
          pc_d = pc_q + (issue.next_long ? PC_SKIP2 : PC_SKIP1);    // [RULE18]
          cyc  = issue.next_long ? CYC_3 : CYC_2;                   // [RULE18]
        end
      end
      OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW, OP_BRANCH_ON_EQUAL,
      OP_BRANCH_UNEQUAL, OP_BRANCH_CARRY_HIGH, OP_BRANCH_CARRY_LOW,
      OP_BRANCH_UNSIGNED_GE: begin
        case (issue.op)
          OP_BRANCH_FLAG_HIGH:  cond = flag_register_q[issue.bit_sel]; // [RULE15]
          OP_BRANCH_FLAG_LOW:   cond = !flag_register_q[issue.bit_sel]; // [RULE15]
          OP_BRANCH_ON_EQUAL:   cond = flag_register_q[FLAG_Z];     // [RULE16]
          OP_BRANCH_UNEQUAL:    cond = !flag_register_q[FLAG_Z];    // [RULE16]
          OP_BRANCH_CARRY_HIGH: cond = flag_register_q[FLAG_C];     // [RULE16]
          default:              cond = !flag_register_q[FLAG_C]; // [RULE16] [RULE17]
        endcase
        if (cond) begin
          pc_d = pc_q + issue.k + PC_STEP;
          cyc  = CYC_2;                                             // [RULE18]
        end
      end
      default: cond = 1'b0;
    endcase
  end

  // Register file: an issued result wins over the load port.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < REG_N; i++) begin
        rf_q[i] <= BYTE_ZERO;
      end
    end else if (clk_en) begin
      if (accept && wr16) begin
        rf_q[dst_lo] <= r16[7:0];                              // [RULE3] [RULE7]
        rf_q[(issue.op == OP_WORD_ADD_IMMEDIATE ||
              issue.op == OP_WORD_SUBTRACT_IMMEDIATE) ? dst_hi
             : IDX_PROD_HI] <= r16[15:8];
      end else if (accept && wr8) begin
        rf_q[issue.rd] <= res8;
      end else if (load.en) begin
        rf_q[load.idx] <= load.data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flag_register_q <= BYTE_ZERO;
    end else if (clk_en) begin
      if (accept) begin
        flag_register_q <= nf;
      end else if (flags_load_en) begin
        flag_register_q <= flags_load_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pc_q       <= PC_RESET;
      push_q     <= 1'b0;
      ret_addr_q <= PC_RESET;
    end else if (clk_en) begin
      push_q <= accept && push_d;
      if (accept) begin
        pc_q <= pc_d;
        if (push_d) begin
          ret_addr_q <= ret_d;                                      // [RULE10]
        end
      end
    end
  end

  // Holds the unit busy for the remaining cycles of a multi-cycle op.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q       <= ST_READY;
      cnt_q         <= CYC_1;
      issue_ready_q <= 1'b1;
      done_q        <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      case (state_q)
        ST_READY: begin
          if (accept) begin
            if (cyc == CYC_1) begin
              done_q <= 1'b1;
            end else begin
              state_q       <= ST_BUSY;
              cnt_q         <= cyc - CYC_1;                         // [RULE18]
              issue_ready_q <= 1'b0;
            end
          end
        end
        ST_BUSY: begin
          if (cnt_q == CYC_1) begin
            state_q       <= ST_READY;
            issue_ready_q <= 1'b1;
            done_q        <= 1'b1;
          end else begin
            cnt_q <= cnt_q - CYC_1;
          end
        end
        default: begin
          state_q       <= ST_READY;
          issue_ready_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      peek_data_q <= BYTE_ZERO;
    end else if (clk_en) begin
      peek_data_q <= rf_q[peek_idx];
    end
  end

endmodule

/* tb/albe_exec_properties.sv */
`timescale 1ns/1ps
module albe_exec_properties
  import albe_pkg::*;
(
  // Clock and control.
  input wire logic            ref_clk,
  input wire logic            sys_rst,
  input wire logic            clk_en,
  // Issue and results.
  input wire logic            issue_valid,
  input wire albe_instr_t     issue,
  input wire logic            issue_ready_q,
  input wire logic            done_q,
  input wire logic [PC_W-1:0] pc_q,
  input wire logic [7:0]      flag_register_q
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  logic tk;
  assign tk = clk_en && issue_valid && issue_ready_q;

  a_add_one_cycle: assert property (
    tk && issue.op == OP_SUM_REGS |=> done_q && issue_ready_q)
    else $error("add did not finish in one cycle");
  a_word_two_cycles: assert property (
    tk && issue.op == OP_WORD_ADD_IMMEDIATE |=> !issue_ready_q ##1 done_q)
    else $error("word add not two cycles");
  a_mul_two_cycles: assert property (
    tk && issue.op == OP_PRODUCT_UNSIGNED |=> !done_q ##1 done_q)
    else $error("multiply not two cycles");
  a_goto_three_cycles: assert property (
    tk && issue.op == OP_ABSOLUTE_GOTO
    |=> !issue_ready_q [*2] ##1 done_q && pc_q == $past(issue.k, 3))
    else $error("absolute goto wrong");
  a_call_four_cycles: assert property (
    tk && issue.op == OP_ABSOLUTE_SUBROUTINE_INVOKE
    |=> !issue_ready_q [*3] ##1 done_q)
    else $error("absolute call not four cycles");
  a_fill_keeps_flags: assert property (
    tk && issue.op == OP_ONES_FILL |=> $stable(flag_register_q))
    else $error("ones fill changed flags");
  a_logic_keeps_ch: assert property (
    tk && issue.op inside {OP_CONJ_REGS, OP_CONJ_IMMEDIATE, OP_DISJ_REGS,
      OP_DISJ_IMMEDIATE, OP_BITWISE_XOR_REGS}
    |=> $stable(flag_register_q[FLAG_C]) && $stable(flag_register_q[FLAG_H]))
    else $error("logic op changed carry or half carry");
  a_branch_taken: assert property (
    tk && issue.op == OP_BRANCH_ON_EQUAL && flag_register_q[FLAG_Z]
    |=> pc_q == $past(pc_q) + $past(issue.k) + PC_STEP && !done_q
    ##1 done_q)
    else $error("taken branch wrong");
  a_branch_untaken: assert property (
    tk && issue.op == OP_BRANCH_UNEQUAL && flag_register_q[FLAG_Z]
    |=> done_q && pc_q == $past(pc_q) + PC_STEP)
    else $error("untaken branch wrong");
  a_skip_long: assert property (
    tk && issue.op == OP_SKIP_PORT_BIT_HIGH && issue.port_bit
    && issue.next_long
    |=> pc_q == $past(pc_q) + PC_SKIP2 && !done_q ##1 !done_q ##1 done_q)
    else $error("long skip wrong");
  a_branch_keeps_flags: assert property (
    tk && issue.op inside {OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW}
    |=> $stable(flag_register_q))
    else $error("branch changed flags");

  c_call: cover property (tk && issue.op == OP_ABSOLUTE_SUBROUTINE_INVOKE);
  c_branch: cover property (tk && issue.op == OP_BRANCH_ON_EQUAL);
  c_skip: cover property (tk && issue.op == OP_EQUAL_COMPARE_SKIP);
endmodule

bind albe_exec_core albe_exec_properties i_albe_exec_properties (
  .ref_clk, .sys_rst, .clk_en, .issue_valid, .issue, .issue_ready_q,
  .done_q, .pc_q, .flag_register_q);

/* tb/arith_logic_branch_exec_test.sv */
`timescale 1ns/1ps
module arith_logic_branch_exec_test
  import albe_pkg::*;
;
  logic            ref_clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic            clk_en = 1'b1;
  logic            issue_valid = 1'b0;
  albe_instr_t     issue = '0;
  albe_load_t      load = '0;
  logic [4:0]      peek_idx = 5'h00;
  logic            flags_load_en = 1'b0;
  logic [7:0]      flags_load_data = 8'h00;
  logic            issue_ready_q, done_q, push_q;
  logic [7:0]      peek_data_q, flag_register_q;
  logic [PC_W-1:0] pc_q, ret_addr_q;
  logic [PC_W-1:0] tpc = PC_RESET;
  logic [2:0]      xb = 3'h0;
  logic            xl = 1'b0;
  logic            xp = 1'b0;
  int              error_cnt = 0;
  int              checks = 0;

  always #20 ref_clk = ~ref_clk;

  albe_exec_core i_albe_exec_core (
    .ref_clk, .sys_rst, .clk_en, .issue_valid, .issue, .issue_ready_q,
    .done_q, .load, .peek_idx, .peek_data_q, .flags_load_en,
    .flags_load_data, .pc_q, .flag_register_q, .push_q, .ret_addr_q);

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic ld(input logic [4:0] i, input logic [7:0] d);
    load = '{1'b1, i, d};
    tick;
    load.en = 1'b0;
    tick;
  endtask

  task automatic setf(input logic [7:0] v);
    flags_load_en = 1'b1;
    flags_load_data = v;
    tick;
    flags_load_en = 1'b0;
  endtask

  task automatic fl(input logic [7:0] e);
    chk({8'h00, flag_register_q}, {8'h00, e});
  endtask

  task automatic rg(input logic [4:0] i, input logic [7:0] e);
    peek_idx = i;
    tick;
    chk({8'h00, peek_data_q}, {8'h00, e});
  endtask

  // Issues one instruction, checks the new pc and the cycle count.
  task automatic run(input albe_op_t o, input logic [4:0] d, r,
                     input logic [7:0] m, input logic [15:0] k,
                     input int ec, input logic [15:0] npc);
    int n;
    issue = '{o, d, r, m, k, xb, xl, xp};
    issue_valid = 1'b1;
    tick;
    issue_valid = 1'b0;
    n = 1;
    chk(pc_q, npc);
    chk(16'(push_q), 16'(o inside {OP_RELATIVE_SUBROUTINE_INVOKE,
        OP_POINTER_SUBROUTINE_INVOKE, OP_ABSOLUTE_SUBROUTINE_INVOKE}));
    while (done_q !== 1'b1 && n < 9) begin
      tick;
      n++;
    end
    chk(16'(n), 16'(ec));
    tpc = npc;
    tick;
  endtask

  task automatic al(input albe_op_t o, input logic [4:0] d, r,
                    input logic [7:0] m, input int ec);
    run(o, d, r, m, 16'h0000, ec, tpc + PC_STEP);
  endtask

  task automatic fw(input albe_op_t o, input logic [15:0] k,
                    input int ec, input logic [15:0] npc);
    run(o, 5'h00, 5'h00, 8'h00, k, ec, npc);
  endtask

  task automatic sk(input albe_op_t o, input logic [4:0] d, r,
                    input int ec, input logic [15:0] step);
    run(o, d, r, 8'h00, 16'h0000, ec, tpc + step);
  endtask

  task automatic t_arith;
    setf(8'h00);
    ld(5'h02, 8'h0F);
    ld(5'h03, 8'h01);
    ld(5'h04, 8'hFF);
    al(OP_SUM_REGS, 5'h02, 5'h03, 8'h00, 1);
    fl(8'h20);
    al(OP_SUM_WITH_CARRY_IN, 5'h04, 5'h03, 8'h00, 1);
    fl(8'h23);
    al(OP_SUM_WITH_CARRY_IN, 5'h02, 5'h03, 8'h00, 1);
    rg(5'h02, 8'h12);
    al(OP_DIFFERENCE_IMMEDIATE, 5'h02, 5'h00, 8'h13, 1);
    fl(8'h25);
    al(OP_DIFFERENCE_IMMEDIATE_BORROW, 5'h02, 5'h00, 8'h00, 1);
    fl(8'h04);
    al(OP_COMPARE_IMMEDIATE, 5'h02, 5'h00, 8'hFF, 1);
    fl(8'h25);
    rg(5'h02, 8'hFE);
  endtask

  task automatic t_word;
    setf(8'h20);
    ld(5'h18, 8'hFF);
    al(OP_WORD_ADD_IMMEDIATE, 5'h18, 5'h00, 8'h01, 2);
    fl(8'h20);
    rg(5'h19, 8'h01);
    al(OP_WORD_SUBTRACT_IMMEDIATE, 5'h1A, 5'h00, 8'h01, 2);
    fl(8'h35);
    rg(5'h1B, 8'hFF);
  endtask

  task automatic t_logic;
    setf(8'h3F);
    ld(5'h06, 8'hF0);
    al(OP_CONJ_IMMEDIATE, 5'h06, 5'h00, 8'h0F, 1);
    fl(8'h33);
    al(OP_ONES_FILL, 5'h06, 5'h00, 8'h00, 1);
    rg(5'h06, 8'hFF);
    al(OP_BITS_CLEAR_MASK, 5'h06, 5'h00, 8'h81, 1);
    rg(5'h06, 8'h7E);
    fl(8'h31);
    al(OP_ZERO_FILL, 5'h06, 5'h00, 8'h00, 1);
    fl(8'h33);
    al(OP_MINUS_ONE, 5'h06, 5'h00, 8'h00, 1);
    fl(8'h35);
  endtask

  task automatic t_mul;
    setf(8'h00);
    ld(5'h10, 8'hFF);
    ld(5'h11, 8'hFF);
    al(OP_PRODUCT_UNSIGNED, 5'h10, 5'h11, 8'h00, 2);
    fl(8'h01);
    rg(5'h01, 8'hFE);
    ld(5'h10, 8'hC0);
    ld(5'h11, 8'h40);
    al(OP_FRACTION_PRODUCT_SIGNED, 5'h10, 5'h11, 8'h00, 2);
    fl(8'h01);
    rg(5'h01, 8'hE0);
  endtask

  task automatic t_flow;
    fw(OP_ABSOLUTE_GOTO, 16'h0100, 3, 16'h0100);
    fw(OP_RELATIVE_GOTO, 16'hFFFE, 2, 16'h00FF);
    ld(5'h1E, 8'h34);
    ld(5'h1F, 8'h12);
    fw(OP_POINTER_GOTO, 16'h0000, 2, 16'h1234);
    fw(OP_ABSOLUTE_SUBROUTINE_INVOKE, 16'h0200, 4, 16'h0200);
    chk(ret_addr_q, 16'h1236);
    fw(OP_RELATIVE_SUBROUTINE_INVOKE, 16'h0010, 3, 16'h0211);
    chk(ret_addr_q, 16'h0201);
    fw(OP_POINTER_SUBROUTINE_INVOKE, 16'h0000, 3, 16'h1234);
    chk(ret_addr_q, 16'h0212);
  endtask

  task automatic t_skip;
    ld(5'h08, 8'h55);
    ld(5'h09, 8'h55);
    xl = 1'b1;
    sk(OP_EQUAL_COMPARE_SKIP, 5'h08, 5'h09, 3, PC_SKIP2);
    xl = 1'b0;
    sk(OP_EQUAL_COMPARE_SKIP, 5'h08, 5'h02, 1, PC_STEP);
    xb = 3'h1;
    sk(OP_SKIP_REG_BIT_LOW, 5'h08, 5'h08, 2, PC_SKIP1);
    sk(OP_SKIP_REG_BIT_HIGH, 5'h08, 5'h08, 1, PC_STEP);
    xp = 1'b1;
    xl = 1'b1;
    sk(OP_SKIP_PORT_BIT_HIGH, 5'h00, 5'h00, 3, PC_SKIP2);
    sk(OP_SKIP_PORT_BIT_LOW, 5'h00, 5'h00, 1, PC_STEP);
    xl = 1'b0;
    sk(OP_SKIP_PORT_BIT_HIGH, 5'h00, 5'h00, 2, PC_SKIP1);
    xp = 1'b0;
  endtask

  task automatic t_branch;
    clk_en = 1'b0;
    setf(8'h02);
    fl(8'h01);
    clk_en = 1'b1;
    tick;
    setf(8'h02);
    fw(OP_BRANCH_ON_EQUAL, 16'h0005, 2, tpc + 16'h0006);
    fw(OP_BRANCH_UNEQUAL, 16'h0005, 1, tpc + PC_STEP);
    fw(OP_BRANCH_CARRY_LOW, 16'hFFF0, 2, tpc - 16'h000F);
    fw(OP_BRANCH_CARRY_HIGH, 16'h0005, 1, tpc + PC_STEP);
    fw(OP_BRANCH_UNSIGNED_GE, 16'h0003, 2, tpc + 16'h0004);
    fw(OP_BRANCH_FLAG_HIGH, 16'h0002, 2, tpc + 16'h0003);
    fw(OP_BRANCH_FLAG_LOW, 16'h0002, 1, tpc + PC_STEP);
    fl(8'h02);
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    finish_test;
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    t_arith;
    t_word;
    t_logic;
    t_mul;
    t_flow;
    t_skip;
    t_branch;
    finish_test;
  end
endmodule
